//--- rtl/media_hdr_regs.vh
// Register map, field positions and timing counts of the media header monitor.
// Assumes a 250 MHz core clock and big-endian 32-bit datagram words.
`ifndef MEDIA_HDR_REGS_VH
`define MEDIA_HDR_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL      8'h00
`define OFS_TS_TOL    8'h04
`define OFS_MK_TOL    8'h08
`define OFS_ERR       8'h0c
`define OFS_RTP_HDR   8'h10
`define OFS_RTP_TS    8'h14
`define OFS_RTP_SSRC  8'h18
`define OFS_HBR_W0    8'h1c
`define OFS_HBR_W1    8'h20
`define OFS_DECODE    8'h24
`define OFS_SEQ_CNT   8'h28

// ****************************************
// Reset values
// ****************************************
`define RST_MODE      2'h0
`define RST_TS_TOL    16'h0010
`define RST_MK_TOL    32'h00002710

// ****************************************
// Stream modes
// ****************************************
`define MODE_HBR      2'h0
`define MODE_VID      2'h1
`define MODE_AUD      2'h2
`define MODE_ANC      2'h3

// ****************************************
// RTP word 0 fields
// ****************************************
`define W0_VER_HI     31
`define W0_VER_LO     30
`define W0_PAD        29
`define W0_EXT        28
`define W0_CC_HI      27
`define W0_CC_LO      24
`define W0_MARK       23
`define W0_PT_HI      22
`define W0_PT_LO      16
`define W0_SEQ_HI     15
`define W0_SEQ_LO     0
`define RTP_VERSION   2'h2
`define PT_HBR        7'h62
`define PT_FEC        7'h63
`define PT_MPTS       7'h21
`define PT_DYN_LO     7'h60
`define PT_DYN_HI     7'h7f

// ****************************************
// Media payload header word 0 and 1 fields
// ****************************************
`define H0_EXT_HI     31
`define H0_EXT_LO     28
`define H0_FMT        27
`define H0_VSID_HI    26
`define H0_VSID_LO    24
`define H0_FC_HI      23
`define H0_FC_LO      16
`define H0_REF_HI     15
`define H0_REF_LO     14
`define H0_SCR_HI     13
`define H0_SCR_LO     12
`define H0_FEC_HI     11
`define H0_FEC_LO     9
`define H0_CF_HI      8
`define H0_CF_LO      5
`define H0_RSV_HI     4
`define H0_RSV_LO     0
`define H1_MAP_HI     31
`define H1_MAP_LO     28
`define H1_FRM_HI     27
`define H1_FRM_LO     20
`define H1_FR_HI      19
`define H1_FR_LO      12
`define H1_SMP_HI     11
`define H1_SMP_LO     8
`define H1_FRSV_HI    7
`define H1_FRSV_LO    0

// ****************************************
// Timing
// ****************************************
`define CLK_HZ        29'd250000000
`define CLK_HZ_64     64'd250000000
`define TICK_27M_HZ   29'd27000000
`define TICK_90K_HZ   29'd90000
`define TICK_48K_HZ   29'd48000
`define FP_INT(r)     (`CLK_HZ_64 / (r))
`define FP_NTSC(r)    (`CLK_HZ_64 * 64'd1001 / ((r) * 64'd1000))

`endif

//--- rtl/rtp_media_header_monitor.v
// RTP and media payload header monitor for one received media stream.
// Assumes datagrams arrive as 32-bit words after IP/UDP removal, sop on the
// RTP word 0, and software on an Avalon-MM slave port.
`include "media_hdr_regs.vh"

module rtp_media_header_monitor (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Avalon-MM slave
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Datagram word stream
  input  wire        in_valid,
  input  wire        in_sop,
  input  wire        in_eop,
  input  wire [31:0] in_data,
  // Payload and status
  output reg         pay_valid,
  output reg  [31:0] pay_data,
  output reg  [7:0]  err_flags
);

  // ****************************************
  // Functions
  // ****************************************
  function [31:0] absdiff;
    input [31:0] a;
    input [31:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // Expected frame period in cycles, zero when the code names no rate
  function [31:0] frame_period;
    input [7:0]  code;
    reg   [63:0] per;
    begin
      case (code)
        8'h10: per = `FP_INT(64'd60);
        8'h11: per = `FP_NTSC(64'd60);
        8'h12: per = `FP_INT(64'd50);
        8'h14: per = `FP_INT(64'd48);
        8'h15: per = `FP_NTSC(64'd48);
        8'h16: per = `FP_INT(64'd30);
        8'h17: per = `FP_NTSC(64'd30);
        8'h18: per = `FP_INT(64'd25);
        8'h1a: per = `FP_INT(64'd24);
        8'h1b: per = `FP_NTSC(64'd24);
        default: per = 64'h0;
      endcase
      // Longest period fits easily in 32 bits
      frame_period = per[31:0];
    end
  endfunction

  function raster_known;
    input [7:0] code;
    begin
      case (code)
        8'h00, 8'h10, 8'h11, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30: raster_known = 1'b1;
        default: raster_known = 1'b0;
      endcase
    end
  endfunction

  function sample_known;
    input [3:0] code;
    begin
      sample_known = (code <= 4'h8) && (code != 4'h4);
    end
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_m_r;
  reg rst_s_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  reg  [1:0]  mode_r;
  reg         en_r;
  reg  [15:0] ts_tol_r;
  reg  [31:0] mk_tol_r;
  reg  [31:0] hdr0_r;
  reg  [31:0] ts_r;
  reg  [31:0] ssrc_r;
  reg  [31:0] hbr0_r;
  reg  [31:0] hbr1_r;
  reg  [15:0] dec_r;
  reg  [15:0] seq_cnt_r;
  reg  [31:0] rd_nxt;

  // One wait cycle: the request is taken on the edge where waitrequest is low
  wire        wr_go    = write & ~waitrequest;
  wire        hist_clr = wr_go & (address == `OFS_CTRL) & writedata[3];
  wire [7:0]  err_clr  = (wr_go && address == `OFS_ERR) ? writedata[7:0] : 8'h00;

  always @*
  begin
    case (address)
      `OFS_CTRL:     rd_nxt = {29'h0, en_r, mode_r};
      `OFS_TS_TOL:   rd_nxt = {16'h0, ts_tol_r};
      `OFS_MK_TOL:   rd_nxt = mk_tol_r;
      `OFS_ERR:      rd_nxt = {24'h0, err_flags};
      `OFS_RTP_HDR:  rd_nxt = hdr0_r;
      `OFS_RTP_TS:   rd_nxt = ts_r;
      `OFS_RTP_SSRC: rd_nxt = ssrc_r;
      `OFS_HBR_W0:   rd_nxt = hbr0_r;
      `OFS_HBR_W1:   rd_nxt = hbr1_r;
      `OFS_DECODE:   rd_nxt = {16'h0, dec_r};
      `OFS_SEQ_CNT:  rd_nxt = {16'h0, seq_cnt_r};
      default:       rd_nxt = 32'h0;
    endcase
  end

  always @(posedge clk or negedge rst_s_r)
  begin
    if (!rst_s_r)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
      mode_r      <= `RST_MODE;
      en_r        <= 1'b0;
      ts_tol_r    <= `RST_TS_TOL;
      mk_tol_r    <= `RST_MK_TOL;
    end
    else
    begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read && waitrequest)
        readdata <= rd_nxt;
      if (wr_go && address == `OFS_CTRL)
      begin
        mode_r <= writedata[1:0];
        en_r   <= writedata[2];
      end
      if (wr_go && address == `OFS_TS_TOL)
        ts_tol_r <= writedata[15:0];
      if (wr_go && address == `OFS_MK_TOL)
        mk_tol_r <= writedata;
    end
  end

  // ****************************************
  // Timestamp tick divider
  // ****************************************
  reg  [28:0] acc_r;
  reg  [28:0] tick_hz;
  wire [28:0] acc_sum = acc_r + tick_hz;
  wire        tick    = (acc_sum >= `CLK_HZ);

  always @*
  begin
    case (mode_r)
      `MODE_HBR: tick_hz = `TICK_27M_HZ;
      `MODE_AUD: tick_hz = `TICK_48K_HZ;
      default:   tick_hz = `TICK_90K_HZ;
    endcase
  end

  always @(posedge clk or negedge rst_s_r)
  begin
    if (!rst_s_r)
      acc_r <= 29'h0;
    else
      acc_r <= tick ? (acc_sum - `CLK_HZ) : acc_sum;
  end

  // ****************************************
  // Header parser and checks
  // ****************************************
  reg  [3:0]  widx_r;
  reg         hbr_pkt_r;
  reg  [4:0]  skip_r;
  reg  [15:0] prev_seq_r;
  reg         seq_vld_r;
  reg  [31:0] prev_ts_r;
  reg         ts_vld_r;
  reg  [31:0] tick_cnt_r;
  reg  [31:0] mk_cnt_r;
  reg  [31:0] mk_prev_r;
  reg         mk_seen_r;
  reg         mk_vld_r;
  reg         fs_next_r;
  reg         fs_cur_r;
  reg  [7:0]  fc_prev_r;
  reg         fc_vld_r;
  reg  [7:0]  frate_r;
  reg  [7:0]  err_set;
  reg  [15:0] dec_nxt;

  wire        w_ok     = in_valid & en_r;
  wire [3:0]  widx     = in_sop ? 4'h0 : widx_r;
  wire        mark     = in_data[`W0_MARK];
  wire [6:0]  pt       = in_data[`W0_PT_HI:`W0_PT_LO];
  wire [15:0] seq      = in_data[`W0_SEQ_HI:`W0_SEQ_LO];
  wire        vid2110  = (mode_r == `MODE_VID) || (mode_r == `MODE_ANC);
  wire        ts_chk   = ~vid2110 | fs_cur_r;
  wire [31:0] ts_delta = in_data - prev_ts_r;
  wire [31:0] fp_exp   = frame_period(frate_r);
  wire [3:0]  cf       = in_data[`H0_CF_HI:`H0_CF_LO];
  wire        mk_rate_bad = (mode_r == `MODE_HBR) ?
                            (fp_exp != 32'h0 && absdiff(mk_cnt_r, fp_exp) > mk_tol_r) :
                            (mk_vld_r && absdiff(mk_cnt_r, mk_prev_r) > mk_tol_r);
  wire        mk_jitter   = mk_vld_r && absdiff(mk_cnt_r, mk_prev_r) > mk_tol_r;

  // Error bits: 0 version, 1 csrc, 2 marker rate, 3 sequence, 4 timestamp,
  // 5 marker jitter, 6 frame count, 7 reserved code seen
  always @*
  begin
    err_set = 8'h00;
    dec_nxt = dec_r;
    if (w_ok && widx == 4'h0)
    begin
      err_set[0] = (in_data[`W0_VER_HI:`W0_VER_LO] != `RTP_VERSION);
      err_set[1] = (in_data[`W0_CC_HI:`W0_CC_LO] != 4'h0);
      err_set[3] = seq_vld_r && (seq != prev_seq_r + 16'h1);
      err_set[2] = mark && mk_seen_r && mk_rate_bad;
      err_set[5] = mark && mk_seen_r && (mk_rate_bad || mk_jitter);
    end
    if (w_ok && widx == 4'h1 && ts_chk && ts_vld_r)
      err_set[4] = (absdiff(ts_delta, tick_cnt_r) > {16'h0, ts_tol_r});
    if (w_ok && hbr_pkt_r && widx == 4'h3)
    begin
      err_set[6] = fs_cur_r && fc_vld_r &&
                   (in_data[`H0_FC_HI:`H0_FC_LO] != fc_prev_r + 8'h01);
      dec_nxt[0] = in_data[`H0_FMT];
      dec_nxt[1] = (in_data[`H0_VSID_HI:`H0_VSID_LO] > 3'h1);
      dec_nxt[2] = (in_data[`H0_REF_HI:`H0_REF_LO] == 2'h1);
      dec_nxt[3] = (in_data[`H0_SCR_HI:`H0_SCR_LO] != 2'h0);
      dec_nxt[4] = (in_data[`H0_FEC_HI:`H0_FEC_LO] > 3'h2);
      dec_nxt[5] = (cf > 4'h5);
      dec_nxt[10] = (in_data[`H0_RSV_HI:`H0_RSV_LO] != 5'h0);
      err_set[7] = |{dec_nxt[5:1], dec_nxt[10]};
    end
    if (w_ok && hbr_pkt_r && widx == 4'h4 && dec_r[0])
    begin
      dec_nxt[6] = (in_data[`H1_MAP_HI:`H1_MAP_LO] > 4'h2);
      dec_nxt[7] = ~raster_known(in_data[`H1_FRM_HI:`H1_FRM_LO]);
      dec_nxt[8] = (frame_period(in_data[`H1_FR_HI:`H1_FR_LO]) == 32'h0) &&
                   (in_data[`H1_FR_HI:`H1_FR_LO] > 8'h04);
      dec_nxt[9] = ~sample_known(in_data[`H1_SMP_HI:`H1_SMP_LO]);
      err_set[7] = |dec_nxt[9:6];
    end
  end

  always @(posedge clk or negedge rst_s_r)
  begin
    if (!rst_s_r)
    begin
      widx_r     <= 4'h0;
      hbr_pkt_r  <= 1'b0;
      skip_r     <= 5'h0;
      prev_seq_r <= 16'h0;
      seq_vld_r  <= 1'b0;
      prev_ts_r  <= 32'h0;
      ts_vld_r   <= 1'b0;
      tick_cnt_r <= 32'h0;
      mk_cnt_r   <= 32'h0;
      mk_prev_r  <= 32'h0;
      mk_seen_r  <= 1'b0;
      mk_vld_r   <= 1'b0;
      fs_next_r  <= 1'b0;
      fs_cur_r   <= 1'b0;
      fc_prev_r  <= 8'h0;
      fc_vld_r   <= 1'b0;
      frate_r    <= 8'h0;
      hdr0_r     <= 32'h0;
      ts_r       <= 32'h0;
      ssrc_r     <= 32'h0;
      hbr0_r     <= 32'h0;
      hbr1_r     <= 32'h0;
      dec_r      <= 16'h0;
      seq_cnt_r  <= 16'h0;
      err_flags  <= 8'h0;
      pay_valid  <= 1'b0;
      pay_data   <= 32'h0;
    end
    else
    begin
      // Set wins over a software clear in the same cycle
      err_flags  <= (err_flags & ~err_clr) | err_set;
      dec_r      <= dec_nxt;
      tick_cnt_r <= tick_cnt_r + {31'h0, tick};
      mk_cnt_r   <= mk_cnt_r + 32'h1;
      pay_valid  <= 1'b0;
      if (err_set[3])
        seq_cnt_r <= seq_cnt_r + 16'h1;
      if (w_ok)
      begin
        widx_r <= (widx == 4'hf) ? widx : widx + 4'h1;
        case (widx)
          4'h0:
          begin
            hdr0_r     <= in_data;
            hbr_pkt_r  <= (pt == `PT_HBR) && (mode_r == `MODE_HBR);
            prev_seq_r <= seq;
            seq_vld_r  <= 1'b1;
            fs_cur_r   <= fs_next_r;
            fs_next_r  <= mark;
            if (mark)
            begin
              mk_cnt_r  <= 32'h1;
              mk_prev_r <= mk_cnt_r;
              mk_vld_r  <= mk_seen_r;
              mk_seen_r <= 1'b1;
            end
          end
          4'h1:
          begin
            ts_r <= in_data;
            if (ts_chk)
            begin
              prev_ts_r  <= in_data;
              ts_vld_r   <= 1'b1;
              tick_cnt_r <= {31'h0, tick};
            end
          end
          4'h2:
            ssrc_r <= in_data;
          4'h3:
          begin
            if (hbr_pkt_r)
            begin
              hbr0_r <= in_data;
              // Video timestamp word, then extension words of four octets
              skip_r <= {4'h0, (cf != 4'h0)} + {1'b0, in_data[`H0_EXT_HI:`H0_EXT_LO]};
              if (fs_cur_r || !fc_vld_r)
              begin
                fc_prev_r <= in_data[`H0_FC_HI:`H0_FC_LO];
                fc_vld_r  <= 1'b1;
              end
            end
            else
            begin
              pay_valid <= 1'b1;
              pay_data  <= in_data;
            end
          end
          4'h4:
          begin
            if (hbr_pkt_r)
            begin
              hbr1_r <= in_data;
              if (in_data[`H1_FR_HI:`H1_FR_LO] != 8'h00)
                frate_r <= in_data[`H1_FR_HI:`H1_FR_LO];
            end
            else
            begin
              pay_valid <= 1'b1;
              pay_data  <= in_data;
            end
          end
          default:
          begin
            if (hbr_pkt_r && skip_r != 5'h0)
              skip_r <= skip_r - 5'h1;
            else
            begin
              pay_valid <= 1'b1;
              pay_data  <= in_data;
            end
          end
        endcase
        if (in_eop)
          widx_r <= 4'h0;
      end
      // History restart keeps field snapshots but forgets continuity
      if (hist_clr)
      begin
        seq_vld_r <= 1'b0;
        ts_vld_r  <= 1'b0;
        mk_seen_r <= 1'b0;
        mk_vld_r  <= 1'b0;
        fc_vld_r  <= 1'b0;
        fs_next_r <= 1'b0;
        seq_cnt_r <= 16'h0;
      end
    end
  end

endmodule // rtp_media_header_monitor

//--- sim/media_hdr_props.sv
// Checker for the media header monitor; sees only the top ports.
// Assumes a bind onto rtp_media_header_monitor and a reset at start.
`include "media_hdr_regs.vh"

module media_hdr_props (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Register bus
  input wire [7:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Stream and status
  input wire        in_valid,
  input wire        in_sop,
  input wire        in_eop,
  input wire [31:0] in_data,
  input wire        pay_valid,
  input wire [31:0] pay_data,
  input wire [7:0]  err_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_r;
  wire  take_wr = write && !waitrequest;
  wire  word0   = en_r && in_valid && in_sop;

  // Shadow of the enable bit, since words are ignored while it is clear
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      en_r <= 1'b0;
    else if (take_wr && address == `OFS_CTRL)
      en_r <= writedata[2];

  // ****************************************
  // Assertions
  // ****************************************
  a_wait_answer: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(read || write) |=> !waitrequest) else $error("no answer one cycle after request");
  a_wait_single: assert property (@(posedge clk) disable iff (!rst_n)
    !waitrequest |=> waitrequest) else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (@(posedge clk) disable iff (!rst_n)
    !waitrequest |-> (read || write)) else $error("answer without a request");
  a_err_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    |($past(err_flags) & ~err_flags) |-> $past(take_wr && address == `OFS_ERR))
    else $error("error flag fell without a clearing write");
  a_ver_flag: assert property (@(posedge clk) disable iff (!rst_n)
    word0 && in_data[31:30] != 2'h2 |=> err_flags[0]) else $error("bad version not flagged");
  a_csrc_flag: assert property (@(posedge clk) disable iff (!rst_n)
    word0 && in_data[27:24] != 4'h0 |=> err_flags[1]) else $error("csrc count not flagged");
  a_pay_source: assert property (@(posedge clk) disable iff (!rst_n)
    pay_valid |-> $past(in_valid && en_r)) else $error("payload without an input word");
  a_err_readback: assert property (@(posedge clk) disable iff (!rst_n)
    read && !waitrequest && address == `OFS_ERR |-> readdata[31:8] == 24'h0)
    else $error("error register upper bits not zero");
endmodule // media_hdr_props

//--- sim/media_sender.sv
// Behavioural network media sender feeding the monitor's word stream.
// Assumes the bench fills words and calls send_pkt after reset.
module media_sender (
  // Clock
  input  wire logic        clk,
  // Datagram words
  output logic             in_valid,
  output logic             in_sop,
  output logic             in_eop,
  output logic [31:0]      in_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] words [0:15];

  initial
  begin
    in_valid = 1'b0;
    in_sop = 1'b0;
    in_eop = 1'b0;
    in_data = 32'h0;
  end

  // Word 0 carries version, csrc count, marker and type as the bench set them
  task automatic send_pkt(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      in_valid <= 1'b1;
      in_sop <= (i == 0);
      in_eop <= (i == n - 1);
      in_data <= words[i];
    end
    @(posedge clk);
    in_valid <= 1'b0;
    in_sop <= 1'b0;
    in_eop <= 1'b0;
    // Inverted idle data so a stale word never looks valid
    in_data <= ~words[n - 1];
  endtask
endmodule // media_sender

//--- sim/rtp_media_header_monitor_tb.sv
// Self-checking bench for the media header monitor.
// Assumes rtl/ is on the include path.
`include "media_hdr_regs.vh"

module rtp_media_header_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address = 8'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  wire  [31:0] readdata;
  wire         waitrequest;
  wire         in_valid;
  wire         in_sop;
  wire         in_eop;
  wire  [31:0] in_data;
  wire         pay_valid;
  wire  [31:0] pay_data;
  wire  [7:0]  err_flags;
  logic [31:0] q;
  logic [31:0] first_pay;
  int          pay_n;
  int          bad_count = 0;
  int          comparisons = 0;
  logic [15:0] seq = 16'h0;
  localparam logic [31:0] row_w0  [6] = '{32'h80620000, 32'h40210000, 32'h81210000,
                                          32'ha0630000, 32'h90600000, 32'h807f0000};
  localparam logic [31:0] row_err [6] = '{32'h0, 32'h1, 32'h2, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] row_pay [6] = '{32'h1, 32'h3, 32'h3, 32'h3, 32'h3, 32'h3};

  always #2 clk = ~clk;

  always @(posedge clk)
    if (pay_valid === 1'b1)
    begin
      if (pay_n == 0)
        first_pay <= pay_data;
      pay_n <= pay_n + 1;
    end

  rtp_media_header_monitor dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .in_valid(in_valid), .in_sop(in_sop), .in_eop(in_eop), .in_data(in_data),
    .pay_valid(pay_valid), .pay_data(pay_data), .err_flags(err_flags));

  media_sender snd (.clk(clk), .in_valid(in_valid), .in_sop(in_sop), .in_eop(in_eop),
    .in_data(in_data));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      test_done();
    end
  endtask

  task automatic pkt(input logic [31:0] w0, input logic [31:0] ts, input int n);
    snd.words[0] = w0 | {16'h0, seq};
    snd.words[1] = ts;
    snd.words[2] = 32'h5a5a0001;
    seq++;
    pay_n = 0;
    snd.send_pkt(n);
    repeat (3) @(posedge clk);
  endtask

  task automatic reset_chk;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    bus(1'b0, `OFS_TS_TOL, 32'h0);
    chk("ts_tol", 32'h10, q);
    bus(1'b0, `OFS_MK_TOL, 32'h0);
    chk("mk_tol", 32'h2710, q);
    bus(1'b0, `OFS_ERR, 32'h0);
    chk("err", 32'h0, q);
    bus(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask

  function automatic logic [31:0] dec_exp(input logic [7:0] v);
    logic [31:0] e;
    e = 32'h1;
    e[1] = v[2:0] > 3'h1;
    e[2] = v[1:0] == 2'h1;
    e[3] = v[1:0] != 2'h0;
    e[4] = v[2:0] > 3'h2;
    e[5] = v[3:0] > 4'h5;
    e[6] = v[3:0] > 4'h2;
    e[7] = !(v inside {8'h00, 8'h10, 8'h11, [8'h20:8'h24], 8'h30});
    e[8] = !(v inside {[8'h00:8'h04], [8'h10:8'h12], [8'h14:8'h18], 8'h1a, 8'h1b});
    e[9] = v[3:0] == 4'h4 || v[3:0] > 4'h8;
    return e;
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    reset_chk();
    bus(1'b1, `OFS_CTRL, 32'hc);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, `OFS_ERR, 32'hff);
      snd.words[3] = 32'h08000000;
      snd.words[4] = 32'h0;
      snd.words[5] = 32'hd0000005;
      pkt(row_w0[i], 32'h0, 6);
      chk("payload count", row_pay[i], pay_n);
      bus(1'b0, `OFS_ERR, 32'h0);
      chk("err", row_err[i], q & 32'h3);
      bus(1'b0, `OFS_RTP_HDR, 32'h0);
      chk("rtp word0", row_w0[i] | {16'h0, seq - 16'h1}, q);
    end
    $display("test rows done");
    for (int v = 0; v < 256; v++)
    begin
      snd.words[3] = {4'h0, 1'b1, v[2:0], v[7:0], v[1:0], v[1:0], v[2:0], v[3:0], 5'h0};
      snd.words[4] = {v[3:0], v[7:0], v[7:0], v[3:0], 8'h0};
      bus(1'b1, `OFS_ERR, 32'hff);
      pkt(32'h80620000, 32'h0, 7);
      bus(1'b0, `OFS_DECODE, 32'h0);
      chk("decode", dec_exp(v[7:0]), q & 32'h7ff);
      bus(1'b0, `OFS_ERR, 32'h0);
      chk("reserved seen", {24'h0, (dec_exp(v[7:0]) & 32'h3fe) != 32'h0, 7'h0}, q & 32'h80);
    end
    $display("test decode sweep done");
    // Header extension of two words plus one for the clock field
    snd.words[3] = 32'h28000020;
    for (int i = 4; i < 10; i++)
      snd.words[i] = 32'hd0000000 + i;
    pkt(32'h80620000, 32'h0, 10);
    chk("payload count", 32'h2, pay_n);
    chk("payload word", 32'hd0000008, first_pay);
    $display("test extension skip done");
    bus(1'b1, `OFS_CTRL, 32'he);
    bus(1'b1, `OFS_ERR, 32'hff);
    seq = 16'hffff;
    pkt(32'h80210000, 32'h0, 4);
    pkt(32'h80210000, 32'h0, 4);
    bus(1'b0, `OFS_ERR, 32'h0);
    chk("seq wrap", 32'h0, q & 32'h8);
    seq++;
    pkt(32'h80210000, 32'h0, 4);
    bus(1'b0, `OFS_ERR, 32'h0);
    chk("seq gap", 32'h8, q & 32'h8);
    bus(1'b0, `OFS_SEQ_CNT, 32'h0);
    chk("seq count", 32'h1, q);
    bus(1'b1, `OFS_ERR, 32'h8);
    bus(1'b0, `OFS_ERR, 32'h0);
    chk("err cleared", 32'h0, q & 32'h8);
    $display("test sequence done");
    for (int m = 0; m < 3; m += 2)
    begin
      bus(1'b1, `OFS_CTRL, 32'hc | m);
      bus(1'b1, `OFS_ERR, 32'hff);
      pkt(32'h80210000, 32'd1000, 4);
      pkt(32'h80210000, 32'd1000, 4);
      bus(1'b0, `OFS_ERR, 32'h0);
      chk("ts steady", 32'h0, q & 32'h10);
      pkt(32'h80210000, 32'd1500, 4);
      bus(1'b0, `OFS_ERR, 32'h0);
      chk("ts jump", 32'h10, q & 32'h10);
    end
    $display("test timestamp done");
    // Steady marker cadence in 2110 video, then one late marker
    bus(1'b1, `OFS_MK_TOL, 32'h2);
    bus(1'b1, `OFS_CTRL, 32'hd);
    bus(1'b1, `OFS_ERR, 32'hff);
    repeat (3) pkt(32'h80a10000, 32'h0, 4);
    bus(1'b0, `OFS_ERR, 32'h0);
    chk("marker steady", 32'h0, q & 32'h24);
    repeat (20) @(posedge clk);
    pkt(32'h80a10000, 32'h0, 4);
    bus(1'b0, `OFS_ERR, 32'h0);
    chk("marker late", 32'h24, q & 32'h24);
    $display("test marker done");
    // Frame counts 5, 6, 8 on marked packets
    bus(1'b1, `OFS_CTRL, 32'hc);
    bus(1'b1, `OFS_ERR, 32'hff);
    for (int k = 5; k < 9; k += k - 4)
    begin
      snd.words[3] = {8'h0, k[7:0], 16'h0};
      snd.words[4] = 32'h0;
      pkt(32'h80e20000, 32'h0, 5);
      bus(1'b0, `OFS_ERR, 32'h0);
      chk("frame count", (k == 8) ? 32'h40 : 32'h0, q & 32'h40);
    end
    $display("test frame count done");
    bus(1'b1, `OFS_CTRL, 32'h0);
    bus(1'b1, `OFS_ERR, 32'hff);
    pkt(32'h41210000, 32'h0, 4);
    bus(1'b0, `OFS_ERR, 32'h0);
    chk("disabled err", 32'h0, q);
    chk("disabled payload", 32'h0, pay_n);
    $display("test disabled done");
    reset_chk();
    test_done();
  end
endmodule // rtp_media_header_monitor_tb

bind rtp_media_header_monitor media_hdr_props props (.clk(clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .in_valid(in_valid), .in_sop(in_sop),
  .in_eop(in_eop), .in_data(in_data), .pay_valid(pay_valid), .pay_data(pay_data),
  .err_flags(err_flags));
